/* hw/iones_status_bytes.sv */
// iones_status_bytes: builds status, fault-type, byte 7, scanner and slot bytes
// assumes all inputs come from logic on clk_i; register port on the same clock
//
// Summary of operation
// RL1 - status bit 0 set while any consumed variable freshness/promptness is invalid
// RL2 - status bit 0 clears only when every indicator is valid
// RL3 - status bit 1 set while any analog module is slow scanned
// RL4 - status bit 2 set while any point is forced, programmer or network
// RL5 - status bit 7 set when nest drops to Ready on network loss
// RL6 - any received command clears status bit 7, valid or not, unless a network failure sets it in the same cycle
// RL7 - in synchronous mode more than three missed end-of-cycle is network failure
// RL8 - failing to consume any one variable is network failure
// RL9 - fault-type bit 1 set on any scanner or I/O fault, else low
// RL10 - fault-type bit 3 set while the scanner fault byte is nonzero
// RL11 - fault-type bit 4 set while any slot is not operational
// RL12 - fault-type bits 0, 2, reserved bits and byte 7 always zero
// RL13 - slot status encoded empty, discordant, operational, user fault or fault
// RL14 - scanner fault bit 2 set on failed store, cleared on good store
`include "iones_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module iones_status_bytes
  import iones_pkg::*;
#(
  parameter int NVAR = 4,
  parameter int NSLOT = 8,
  parameter int PW = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [NVAR-1:0] var_fresh_ok_i,
  input wire logic [NVAR-1:0] var_prompt_ok_i,
  input wire logic [NVAR-1:0] var_consumed_i,
  input wire logic eoc_i,
  input wire logic slow_scan_i,
  input wire logic force_programmer_i,
  input wire logic force_network_i,
  input wire logic command_rx_i,
  input wire logic store_done_i,
  input wire logic store_ok_i,
  input wire logic [7:0] scan_fault_ext_i,
  input wire logic [NSLOT-1:0] slot_present_i,
  input wire logic [NSLOT-1:0] slot_match_i,
  input wire logic [NSLOT-1:0] slot_running_i,
  input wire logic [NSLOT-1:0] slot_user_fault_i,
  output logic [7:0] status_byte_o,
  output logic [7:0] fault_byte_o,
  output logic [7:0] unused_byte_o,
  output logic [7:0] scan_fault_o,
  output logic [8*NSLOT-1:0] slot_status_o,
  output logic ready_lost_o,
  output logic irq_o
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (NVAR < 1 || NVAR > 32)
  begin : g_chk_var
    $error("NVAR must be 1 to 32");
  end
  if (NSLOT < 1 || NSLOT > 8)
  begin : g_chk_slot
    $error("NSLOT must be 1 to 8");
  end
  if (PW < 2 || PW > 32)
  begin : g_chk_pw
    $error("PW must be 2 to 32");
  end
  if ((`IONES_PERIOD_RST >> PW) != 0)
  begin : g_chk_rst
    $error("PW too narrow for the reset period");
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic sync_mode_q;
  logic [PW-1:0] period_q;
  logic [`IONES_NUM_EV-1:0] int_stat_q;
  logic [`IONES_NUM_EV-1:0] int_stat_d;
  logic [`IONES_NUM_EV-1:0] int_en_q;
  logic [NVAR-1:0] seen_q;
  logic [NVAR-1:0] seen_d;
  iones_link_type link_q;
  iones_link_type link_d;
  logic store_fail_q;
  logic [7:0] status_d;
  logic [7:0] fault_d;
  logic [7:0] scan_d;
  logic [31:0] rdata_d;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire sel_ctrl = (addr_i == `IONES_OFF_CTRL);
  wire sel_period = (addr_i == `IONES_OFF_PERIOD);
  wire sel_msg = (addr_i == `IONES_OFF_MSG);
  wire sel_scan = (addr_i == `IONES_OFF_SCAN);
  wire sel_stat = (addr_i == `IONES_OFF_INT_STAT);
  wire sel_clr = (addr_i == `IONES_OFF_INT_CLR);
  wire sel_en = (addr_i == `IONES_OFF_INT_EN);
  wire wr_ctrl = wr_i && sel_ctrl;
  wire wr_period = wr_i && sel_period;
  wire wr_clr = wr_i && sel_clr;
  wire wr_en = wr_i && sel_en;

  // ----------------------------------------
  // end-of-cycle watch and consumption check
  // ----------------------------------------
  logic window;
  logic miss_fail;

  iones_miss_cnt #(
    .PW(PW)
  ) u_miss (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .eoc_i(eoc_i),
    .sync_mode_i(sync_mode_q),
    .period_i(period_q),
    .window_o(window),
    .fail_o(miss_fail)
  );

  wire [NVAR-1:0] seen_now = seen_q | var_consumed_i;
  wire consume_fail = window && (seen_now != {NVAR{1'b1}}); // RL8
  wire net_fail = miss_fail || consume_fail; // RL7 RL8
  assign seen_d = window ? '0 : seen_now;

  // ----------------------------------------
  // network-loss Ready flag, set wins over clear
  // ----------------------------------------
  assign link_d = net_fail ? IONES_LINK_LOST :
                  command_rx_i ? IONES_LINK_OK : link_q; // RL5 RL6
  wire cmd_cleared = command_rx_i && !net_fail && (link_q == IONES_LINK_LOST);

  // ----------------------------------------
  // slot encoders
  // ----------------------------------------
  logic [NSLOT-1:0] slot_fault;
  iones_slot_type slot_code [NSLOT];

  for (genvar s = 0; s < NSLOT; s++)
  begin : g_slot
    iones_slot_eval u_slot (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .present_i(slot_present_i[s]),
      .match_i(slot_match_i[s]),
      .running_i(slot_running_i[s]),
      .user_fault_i(slot_user_fault_i[s]),
      .code_o(slot_code[s]),
      .fault_o(slot_fault[s])
    );
  end

  // ----------------------------------------
  // message bytes
  // ----------------------------------------
  wire fresh_bad = |(~(var_fresh_ok_i & var_prompt_ok_i)); // RL1 RL2
  wire store_fail_evt = store_done_i && !store_ok_i;
  wire store_fail_d = store_done_i ? !store_ok_i : store_fail_q; // RL14
  wire io_fault = |slot_fault; // RL11
  wire scan_fault_any = |scan_d; // RL10

  assign scan_d = (scan_fault_ext_i & `IONES_SF_EXT_MASK)
                | (8'h01 << `IONES_SF_STORE) & {8{store_fail_d}}; // RL14

  always_comb
  begin
    status_d = 8'h00; // RL12
    status_d[`IONES_ST_FRESH] = fresh_bad; // RL1 RL2
    status_d[`IONES_ST_SLOW] = slow_scan_i; // RL3
    status_d[`IONES_ST_FORCED] = force_programmer_i || force_network_i; // RL4
    status_d[`IONES_ST_READY_LOST] = (link_d == IONES_LINK_LOST); // RL5
    fault_d = 8'h00; // RL12
    fault_d[`IONES_FT_NONBLOCK] = scan_fault_any || io_fault; // RL9
    fault_d[`IONES_FT_SCANNER] = scan_fault_any; // RL10
    fault_d[`IONES_FT_IOMOD] = io_fault; // RL11
  end

  // ----------------------------------------
  // interrupt status, set wins over clear
  // ----------------------------------------
  wire [`IONES_NUM_EV-1:0] ev_set = {store_fail_evt, cmd_cleared, net_fail};
  wire [`IONES_NUM_EV-1:0] ev_clr = wr_clr ? wdata_i[`IONES_NUM_EV-1:0] : '0;
  assign int_stat_d = ev_set | (int_stat_q & ~ev_clr);

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (rd_i)
    begin
      if (sel_ctrl)
      begin
        rdata_d[`IONES_CTRL_SYNC] = sync_mode_q;
      end
      else if (sel_period)
      begin
        rdata_d[PW-1:0] = period_q;
      end
      else if (sel_msg)
      begin
        rdata_d = {scan_fault_o, unused_byte_o, fault_byte_o, status_byte_o};
      end
      else if (sel_scan)
      begin
        rdata_d[7:0] = scan_fault_o;
      end
      else if (sel_stat)
      begin
        rdata_d[`IONES_NUM_EV-1:0] = int_stat_q;
      end
      else if (sel_en)
      begin
        rdata_d[`IONES_NUM_EV-1:0] = int_en_q;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync_mode_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      sync_mode_q <= wdata_i[`IONES_CTRL_SYNC];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      period_q <= PW'(`IONES_PERIOD_RST);
    end
    else if (wr_period)
    begin
      period_q <= wdata_i[PW-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      int_en_q <= '0;
    end
    else if (wr_en)
    begin
      int_en_q <= wdata_i[`IONES_NUM_EV-1:0];
    end
  end

  // ----------------------------------------
  // network-loss and consumption state
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      link_q <= IONES_LINK_OK;
      seen_q <= '0;
    end
    else
    begin
      link_q <= link_d;
      seen_q <= seen_d;
    end
  end

  // ----------------------------------------
  // scanner and interrupt state
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      store_fail_q <= 1'b0;
      int_stat_q <= '0;
    end
    else
    begin
      store_fail_q <= store_fail_d;
      int_stat_q <= int_stat_d;
    end
  end

  // ----------------------------------------
  // message outputs
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_o <= 32'h0000_0000;
      status_byte_o <= 8'h00;
      fault_byte_o <= 8'h00;
      unused_byte_o <= 8'h00;
      scan_fault_o <= 8'h00;
      ready_lost_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      rdata_o <= rdata_d;
      status_byte_o <= status_d;
      fault_byte_o <= fault_d;
      unused_byte_o <= 8'h00; // RL12
      scan_fault_o <= scan_d;
      ready_lost_o <= (link_d == IONES_LINK_LOST);
      irq_o <= |(int_stat_d & int_en_q);
    end
  end

  // ----------------------------------------
  // slot status bytes
  // ----------------------------------------
  always_comb
  begin
    slot_status_o = '0;
    for (int i = 0; i < NSLOT; i++)
    begin
      slot_status_o[8*i +: 8] = slot_code[i];
    end
  end

endmodule : iones_status_bytes
`default_nettype wire

/* inc/iones_consts.svh */
// iones_consts.svh: offsets, field positions, reset values and counts
// assumes inclusion by bare name from the status-byte design files
`ifndef IONES_CONSTS_SVH
`define IONES_CONSTS_SVH

// ----------------------------------------
// register word offsets
// ----------------------------------------
`define IONES_OFF_CTRL 8'h00
`define IONES_OFF_PERIOD 8'h04
`define IONES_OFF_MSG 8'h08
`define IONES_OFF_SCAN 8'h0c
`define IONES_OFF_INT_STAT 8'h10
`define IONES_OFF_INT_CLR 8'h14
`define IONES_OFF_INT_EN 8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define IONES_ST_FRESH 0
`define IONES_ST_SLOW 1
`define IONES_ST_FORCED 2
`define IONES_ST_READY_LOST 7
`define IONES_FT_NONBLOCK 1
`define IONES_FT_SCANNER 3
`define IONES_FT_IOMOD 4
`define IONES_SF_STORE 2
`define IONES_SF_EXT_MASK 8'h58
`define IONES_CTRL_SYNC 0
`define IONES_EV_NETFAIL 0
`define IONES_EV_CMDCLR 1
`define IONES_EV_STOREFAIL 2

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define IONES_PERIOD_RST 16'h03e8
`define IONES_MISS_LIMIT 3
`define IONES_NUM_EV 3

`endif

/* inc/iones_pkg.sv */
// iones_pkg: types shared by the status-byte design files
// assumes nothing beyond a SystemVerilog compiler
package iones_pkg;

  // slot status codes as sent in the message
  typedef enum logic [7:0] {
    IONES_SLOT_EMPTY = 8'h01,
    IONES_SLOT_DISCORD = 8'h02,
    IONES_SLOT_OPER = 8'h04,
    IONES_SLOT_USERF = 8'h05,
    IONES_SLOT_FAULT = 8'hff
  } iones_slot_type;

  // state of the network-loss flag
  typedef enum logic [0:0] {
    IONES_LINK_OK = 1'b0,
    IONES_LINK_LOST = 1'b1
  } iones_link_type;

endpackage : iones_pkg

/* hw/iones_slot_eval.sv */
// iones_slot_eval: encodes one slot's status byte and fault flag
// assumes slot condition inputs come from logic on clk_i
`timescale 1ns/100ps
`default_nettype none
module iones_slot_eval
  import iones_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic present_i,
  input wire logic match_i,
  input wire logic running_i,
  input wire logic user_fault_i,
  output var iones_pkg::iones_slot_type code_o,
  output logic fault_o
);

  iones_slot_type code_d;
  iones_slot_type code_q;

  // ----------------------------------------
  // encoding, worst condition first
  // ----------------------------------------
  assign code_d = !present_i ? IONES_SLOT_EMPTY :
                  !match_i ? IONES_SLOT_DISCORD :
                  !running_i ? IONES_SLOT_FAULT :
                  user_fault_i ? IONES_SLOT_USERF : IONES_SLOT_OPER; // RL13

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      code_q <= IONES_SLOT_EMPTY;
    end
    else
    begin
      code_q <= code_d;
    end
  end

  assign code_o = code_q;
  assign fault_o = (code_q != IONES_SLOT_OPER); // RL11

endmodule : iones_slot_eval
`default_nettype wire

/* hw/iones_miss_cnt.sv */
// iones_miss_cnt: watches end-of-cycle events and closes observation windows
// assumes eoc_i is a one-cycle pulse from logic on clk_i
`include "iones_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module iones_miss_cnt #(
  parameter int PW = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic eoc_i,
  input wire logic sync_mode_i,
  input wire logic [PW-1:0] period_i,
  output logic window_o,
  output logic fail_o
);

  logic [PW-1:0] timer_q;
  logic [2:0] miss_q;
  logic expire;
  logic fail_d;

  // ----------------------------------------
  // window timer and miss count
  // ----------------------------------------
  assign expire = (timer_q >= period_i) && !eoc_i;
  assign window_o = sync_mode_i ? eoc_i : expire;
  assign fail_d = sync_mode_i && expire && (miss_q == 3'(`IONES_MISS_LIMIT)); // RL7

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      timer_q <= '0;
      miss_q <= '0;
      fail_o <= 1'b0;
    end
    else
    begin
      fail_o <= fail_d;
      if (eoc_i || expire)
      begin
        timer_q <= '0;
      end
      else
      begin
        timer_q <= timer_q + PW'(1);
      end
      if (eoc_i || !sync_mode_i)
      begin
        miss_q <= '0;
      end
      else if (expire && miss_q != 3'(`IONES_MISS_LIMIT + 1))
      begin
        miss_q <= miss_q + 3'd1; // RL7
      end
    end
  end

endmodule : iones_miss_cnt
`default_nettype wire

/* verif/iones_status_bytes_assertions.sv */
// checker for the status-byte block, sees only top-level ports
// assumes one clock clk_i and async active-low reset nrst_i
`timescale 1ns/100ps
`default_nettype none
module iones_status_checker #(
  parameter int NVAR = 4,
  parameter int NSLOT = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [NVAR-1:0] var_fresh_ok_i,
  input wire logic [NVAR-1:0] var_prompt_ok_i,
  input wire logic slow_scan_i,
  input wire logic force_programmer_i,
  input wire logic force_network_i,
  input wire logic command_rx_i,
  input wire logic store_done_i,
  input wire logic store_ok_i,
  input wire logic [7:0] status_byte_o,
  input wire logic [7:0] fault_byte_o,
  input wire logic [7:0] unused_byte_o,
  input wire logic [7:0] scan_fault_o,
  input wire logic [8*NSLOT-1:0] slot_status_o,
  input wire logic ready_lost_o
);
  // ------------------------------
  // helper and properties
  // ------------------------------
  logic slot_bad;
  logic all_ok;
  always_comb
  begin
    slot_bad = 1'b0;
    for (int i = 0; i < NSLOT; i++)
      slot_bad = slot_bad | (slot_status_o[8*i +: 8] != 8'h04);
  end
  assign all_ok = &(var_fresh_ok_i & var_prompt_ok_i);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_fresh_set: assert property (!all_ok |=> status_byte_o[0])
    else $error("fresh flag not set");
  chk_fresh_clear: assert property (all_ok |=> !status_byte_o[0])
    else $error("fresh flag not cleared");
  chk_slow_flag: assert property (1'b1 |=> status_byte_o[1] == $past(slow_scan_i))
    else $error("slow scan flag wrong");
  chk_forced_flag: assert property (1'b1 |=> status_byte_o[2] == $past(force_programmer_i | force_network_i))
    else $error("forced flag wrong");
  chk_ready_mirror: assert property (ready_lost_o == status_byte_o[7])
    else $error("ready flag mismatch");
  chk_ready_fall: assert property ($fell(ready_lost_o) |-> $past(command_rx_i))
    else $error("ready flag fell without command");
  chk_fault_set: assert property (1'b1 |=> fault_byte_o[4] == $past(slot_bad) &&
    fault_byte_o[3] == (scan_fault_o != 8'h00) && fault_byte_o[1] == ($past(slot_bad) || scan_fault_o != 8'h00))
    else $error("fault type bits wrong");
  chk_fault_clear: assert property ((!slot_bad && scan_fault_o == 8'h00) [*3] |-> fault_byte_o[4:1] == 4'h0)
    else $error("fault type bits not clear");
  chk_zero_bits: assert property (status_byte_o[6:3] == 4'h0 && fault_byte_o[0] == 1'b0 &&
    fault_byte_o[2] == 1'b0 && fault_byte_o[7:5] == 3'h0 && unused_byte_o == 8'h00)
    else $error("reserved bits not zero");
  chk_store_bit: assert property (store_done_i |=> scan_fault_o[2] == !$past(store_ok_i))
    else $error("store failure bit wrong");
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read cycle");
  cov_ready: cover property ($rose(ready_lost_o));
  cov_store: cover property (store_done_i && !store_ok_i);
  cov_slot: cover property (fault_byte_o[4]);
endmodule : iones_status_checker
`default_nettype wire

/* verif/iones_host_model.sv */
// network host model: end-of-cycle, variable delivery, commands
// assumes the bench drives run, skip and command request on clk_i
`timescale 1ns/100ps
`default_nettype none
module iones_host_model #(
  parameter int NVAR = 4,
  parameter int GAP = 3
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic [NVAR-1:0] skip_i,
  input wire logic cmd_req_i,
  output logic eoc_o,
  output logic [NVAR-1:0] consumed_o,
  output logic cmd_o
);
  // ------------------------------
  // cycle generator
  // ------------------------------
  int cnt;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt <= 0;
      eoc_o <= 1'b0;
      consumed_o <= '0;
      cmd_o <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      eoc_o <= run_i && cnt == 1;
      consumed_o <= (run_i && cnt == 0) ? ~skip_i : '0;
      cmd_o <= cmd_req_i;
    end
  end
endmodule : iones_host_model
`default_nettype wire

/* verif/test_io_nest_status_bytes.sv */
// bench for the status-byte block with host model and checker
// assumes the design files and the constants header are compiled first
`include "iones_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module test_io_nest_status_bytes;
  import iones_pkg::*;
  // ------------------------------
  // signals and instances
  // ------------------------------
  localparam int NS = 8;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [3:0] fr = '1, pr = '1, skip = '0, cons;
  logic slow = 0, fp = 0, fn = 0, run = 0, cmdreq = 0, stdone = 0, stok = 0, eoc, cmd, rl, irq;
  logic [7:0] ext = '0, st, ft, sc, unused;
  logic [NS-1:0] pres = '1, mat = '1, runn = '1, uf = '0;
  logic [8*NS-1:0] slots, es;
  logic [31:0] r, t;
  logic sf, bad, good, sev;
  logic [7:0] esc, eft;
  int seed, err_total, total_checks;
  always #50 clk_i = ~clk_i;
  iones_host_model host (.clk_i(clk_i), .nrst_i(nrst_i), .run_i(run), .skip_i(skip),
    .cmd_req_i(cmdreq), .eoc_o(eoc), .consumed_o(cons), .cmd_o(cmd));
  iones_status_bytes dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .var_fresh_ok_i(fr), .var_prompt_ok_i(pr),
    .var_consumed_i(cons), .eoc_i(eoc), .slow_scan_i(slow), .force_programmer_i(fp),
    .force_network_i(fn), .command_rx_i(cmd), .store_done_i(stdone), .store_ok_i(stok),
    .scan_fault_ext_i(ext), .slot_present_i(pres), .slot_match_i(mat), .slot_running_i(runn),
    .slot_user_fault_i(uf), .status_byte_o(st), .fault_byte_o(ft), .unused_byte_o(unused),
    .scan_fault_o(sc), .slot_status_o(slots), .ready_lost_o(rl), .irq_o(irq));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    if (err_total == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
    @(posedge clk_i);
  endtask : bus_rd
  task automatic wait_ready(input int n);
    int k;
    k = 0;
    while (rl !== 1'b1 && k < n)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask : wait_ready
  function automatic logic [8*NS-1:0] exp_slots(input logic [NS-1:0] p, m, q, u);
    for (int i = 0; i < NS; i++)
      exp_slots[8*i +: 8] = !p[i] ? 8'h01 : !m[i] ? 8'h02 : !q[i] ? 8'hff : u[i] ? 8'h05 : 8'h04;
  endfunction : exp_slots
  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    seed = 32'h6e5b;
    sf = 1'b0;
    sev = 1'b0;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    run <= 1'b1;
    @(posedge clk_i);
    bus_wr(`IONES_OFF_PERIOD, 32'h4);
    bus_wr(`IONES_OFF_CTRL, 32'h1);
    bus_rd(`IONES_OFF_CTRL, 32'h1);
    bus_rd(`IONES_OFF_PERIOD, 32'h4);
    bus_rd(8'h1c, 32'h0);
    bus_wr(`IONES_OFF_INT_STAT, 32'h7);
    bus_rd(`IONES_OFF_INT_STAT, 32'h0);
    bus_rd(`IONES_OFF_INT_EN, 32'h0);
    bus_wr(`IONES_OFF_INT_EN, 32'h7);
    for (int i = 0; i < 150; i++)
    begin
      r = $random(seed);
      t = $random(seed);
      good = i < 2 || t[28];
      fr <= (i < 2) ? {3'h7, i == 0} : r[3:0] | r[7:4];
      pr <= (i < 2) ? 4'hf : r[11:8] | r[15:12];
      {slow, fp, fn} <= (i < 2) ? 3'h0 : r[18:16];
      ext <= (i < 2) ? 8'h0 : r[26:19] & {8{r[27]}};
      stdone <= i >= 2 && r[28];
      stok <= r[29];
      if (i >= 2 && r[28])
        sf = !r[29];
      sev = sev || (i >= 2 && r[28] && !r[29]);
      pres <= good ? '1 : ~(t[7:0] & t[15:8]);
      mat <= good ? '1 : ~(t[15:8] & t[23:16]);
      runn <= good ? '1 : ~(t[7:0] & t[23:16]);
      uf <= good ? '0 : t[7:0] & t[31:24];
      @(posedge clk_i);
      stdone <= 1'b0;
      repeat (3) @(posedge clk_i);
      es = exp_slots(pres, mat, runn, uf);
      bad = es != {NS{8'h04}};
      esc = (ext & 8'h58) | {5'h0, sf, 2'h0};
      eft = {3'h0, bad, esc != 0, 1'b0, bad || esc != 0, 1'b0};
      chk(slots, es);
      chk(st, {5'h0, fp | fn, slow, ~&(fr & pr)});
      chk({unused, ft, sc}, {8'h0, eft, esc});
      bus_rd(`IONES_OFF_MSG, {esc, 8'h0, eft, 5'h0, fp | fn, slow, ~&(fr & pr)});
    end
    bus_rd(`IONES_OFF_INT_STAT, {29'h0, sev, 2'h0});
    chk(irq, sev);
    bus_wr(`IONES_OFF_INT_CLR, 32'h7);
    run <= 1'b0;
    repeat (19) @(posedge clk_i);
    chk(rl, 1'b0);
    wait_ready(14);
    chk({rl, st[7]}, 2'h3);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    bus_rd(`IONES_OFF_INT_STAT, 32'h1);
    bus_wr(`IONES_OFF_INT_EN, 32'h0);
    @(posedge clk_i);
    chk(irq, 1'b0);
    bus_wr(`IONES_OFF_INT_EN, 32'h7);
    run <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(rl, 1'b1);
    cmdreq <= 1'b1;
    @(posedge clk_i);
    cmdreq <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({rl, st[7]}, 2'h0);
    bus_rd(`IONES_OFF_INT_STAT, 32'h3);
    bus_wr(`IONES_OFF_INT_CLR, 32'h7);
    bus_rd(`IONES_OFF_INT_STAT, 32'h0);
    chk(irq, 1'b0);
    skip <= 4'h4;
    wait_ready(12);
    chk(rl, 1'b1);
    skip <= 4'h0;
    repeat (6) @(posedge clk_i);
    cmdreq <= 1'b1;
    @(posedge clk_i);
    cmdreq <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(rl, 1'b0);
    bus_wr(`IONES_OFF_CTRL, 32'h0);
    run <= 1'b0;
    wait_ready(20);
    chk(rl, 1'b1);
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    summarize();
  end
endmodule : test_io_nest_status_bytes
bind iones_status_bytes iones_status_checker #(.NVAR(NVAR), .NSLOT(NSLOT)) u_chk (.clk_i(clk_i),
  .nrst_i(nrst_i), .rd_i(rd_i), .rdata_o(rdata_o), .var_fresh_ok_i(var_fresh_ok_i),
  .var_prompt_ok_i(var_prompt_ok_i), .slow_scan_i(slow_scan_i), .force_programmer_i(force_programmer_i),
  .force_network_i(force_network_i), .command_rx_i(command_rx_i), .store_done_i(store_done_i),
  .store_ok_i(store_ok_i), .status_byte_o(status_byte_o), .fault_byte_o(fault_byte_o),
  .unused_byte_o(unused_byte_o), .scan_fault_o(scan_fault_o), .slot_status_o(slot_status_o),
  .ready_lost_o(ready_lost_o));
`default_nettype wire
